// ---- rtl/sfi_flags_ip.sv ----
// Behaviour
// - step flag set traps after every retired instruction; clear means no trap.
// - interrupt-enable flag gates maskable interrupt requests.
// - I/O access allowed only while current privilege <= I/O privilege field.
// - I/O privilege field changes only by pop-flags or interrupt-return at level 0.
// - nested-task flag follows the link of the current task.
// - resume flag suppresses debug faults for the next instruction.
// - virtual-8086 flag selects virtual-8086 mode; clear returns to protected mode.
// - alignment checking only when both alignment flag and mask bit are set.
// - virtual interrupt image acts with pending flag only when extensions enabled.
// - virtual pending flag changed by software only, hardware only reads it.
// - probe flag freely writable to 0 and 1, showing identify support.
// - widened word is 64 bits, upper half reserved, lower half as 32-bit.
// - pointer holds next offset, steps in line, moved by transfers.
// - pointer not directly accessible, changed only by transfers and events; the code also steps it by len on every in-line op.
// - call pushes return pointer; return loads pointer from stack value.
// - prefetch address runs ahead and need not equal the pointer.
// - in 64-bit mode the pointer holds a full 64-bit offset.
// - relative address is displacement plus pointer of next instruction.
`default_nettype none
module sfi_flags_ip
    import sfi_pkg::*;
#(
    parameter logic [63:0] IP_RESET = SFI_IP_RESET
)(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire sfi_cmd_s    cmd,
    input  wire sfi_env_s    env,
    input  wire logic        intrPin,
    input  wire logic        fetchAck,
    output logic      [63:0] flagsWord,
    output logic      [63:0] ipOut,
    output logic      [63:0] fetchAddr,
    output logic      [63:0] pushValue,
    output logic             stepTrap,
    output logic             intrAccept,
    output logic             ioAllowed,
    output logic             alignFault,
    output logic             debugFault,
    output logic             v86Mode,
    output logic             virtIntrPending,
    output logic      [63:0] ripRelAddr
);
    sfi_state_s  cur;
    sfi_state_s  nxt_cur;
    logic [1:0]  io_privilege_level;
    logic [63:0] seqIp;
    logic [63:0] ipMask;
    logic [31:0] wrMask;
    logic [31:0] loaded;
    logic        transfer;
    logic        vInterceptMode;
    logic [2:0]  sizeMask;

    // decoded views of the held flags, pointer mask, next pointer and transfer decode
    always_comb begin
        io_privilege_level           = cur.flags[SFI_BIT_IO_PRIVILEGE_LEVEL_HI:SFI_BIT_IO_PRIVILEGE_LEVEL_LO];
        ipMask         = env.mode64 ? '1 : SFI_ADDR32_MASK;
        seqIp          = (cur.ip + {60'h0, cmd.len}) & ipMask;
        vInterceptMode = cur.flags[SFI_BIT_V86] && env.vmeEnable && (io_privilege_level != SFI_IO_PRIVILEGE_LEVEL_TOP);
        transfer       = (cmd.op != SFI_OP_NONE) && (cmd.op != SFI_OP_SEQ)
                         && (cmd.op != SFI_OP_POP_FLAGS_INSTR) && (cmd.op != SFI_OP_CLI)
                         && (cmd.op != SFI_OP_STI);
    end

    // write mask for a flags load: which bits the popped image may change
    always_comb begin
        wrMask = 32'h0;
        if (cmd.op == SFI_OP_POP_FLAGS_INSTR) begin
            wrMask = SFI_POP_FLAGS_INSTR_MASK;
            if (env.current_privilege_level == SFI_CPL0) begin
                wrMask = wrMask | SFI_IO_PRIVILEGE_LEVEL_MASK;
            end
        end else if (cmd.op == SFI_OP_INTERRUPT_RETURN_INSTR) begin
            wrMask = SFI_INTERRUPT_RETURN_INSTR_MASK;
            if (env.current_privilege_level == SFI_CPL0) begin
                wrMask = wrMask | SFI_INTERRUPT_RETURN_INSTR_PRIV;
            end
        end
        // interrupt enable follows the popped image only when allowed to touch it
        if (((cmd.op == SFI_OP_POP_FLAGS_INSTR) || (cmd.op == SFI_OP_INTERRUPT_RETURN_INSTR)) && (env.current_privilege_level <= io_privilege_level)) begin
            wrMask[SFI_BIT_INTEN] = 1'b1;
        end
        // reserved bits never follow the image and the fixed one stays set
        loaded = (cur.flags & ~wrMask) | (cmd.flagsVal & wrMask) | SFI_FIXED_ONES;
    end

    // next-state logic of flags, pointer, prefetch and synchroniser
    always_comb begin
        nxt_cur          = cur;
        nxt_cur.intrSync = {cur.intrSync[0], intrPin};
        nxt_cur.stepTrap = 1'b0;
        // prefetch runs ahead on its own; only a transfer pulls it back
        if (fetchAck) begin
            nxt_cur.fetch = (cur.fetch + SFI_FETCH_STEP) & ipMask;
        end
        if (cmd.op != SFI_OP_NONE) begin
            // a retired instruction raises the trap when stepping was on at its start
            nxt_cur.stepTrap = cur.flags[SFI_BIT_STEP];
            // a completed instruction other than pop-flags and interrupt-return consumes the resume flag
            nxt_cur.flags[SFI_BIT_RESUME] = 1'b0;
            nxt_cur.ip = seqIp;
        end
        unique case (cmd.op)
            SFI_OP_NONE, SFI_OP_SEQ: begin
            end
            SFI_OP_JMP: begin
                nxt_cur.ip = cmd.target & ipMask;
            end
            SFI_OP_JCC: begin
                nxt_cur.ip = cmd.jccTaken ? (cmd.target & ipMask) : seqIp;
            end
            SFI_OP_CALL: begin
                nxt_cur.pushVal = seqIp;
                nxt_cur.ip      = cmd.target & ipMask;
            end
            SFI_OP_RET: begin
                nxt_cur.ip = cmd.stackVal & ipMask;
            end
            SFI_OP_INTERRUPT_RETURN_INSTR: begin
                nxt_cur.ip    = cmd.stackVal & ipMask;
                nxt_cur.flags = loaded;
            end
            SFI_OP_POP_FLAGS_INSTR: begin
                nxt_cur.flags = loaded;
            end
            SFI_OP_INTR: begin
                // the interrupted pointer is pushed, handler entry clears the controls
                nxt_cur.pushVal = cur.ip;
                nxt_cur.ip      = cmd.target & ipMask;
                nxt_cur.flags[SFI_BIT_STEP]   = 1'b0;
                nxt_cur.flags[SFI_BIT_INTEN]  = 1'b0;
                nxt_cur.flags[SFI_BIT_NEST]   = 1'b0;
                nxt_cur.flags[SFI_BIT_V86]    = 1'b0;
            end
            SFI_OP_CLI, SFI_OP_STI: begin
                // inside virtual-8086 with extensions and I/O privilege below 3 the image takes the change
                if (vInterceptMode) begin
                    nxt_cur.flags[SFI_BIT_VIMAGE] = (cmd.op == SFI_OP_STI);
                end else if (env.current_privilege_level <= io_privilege_level) begin
                    nxt_cur.flags[SFI_BIT_INTEN] = (cmd.op == SFI_OP_STI);
                end
            end
            SFI_OP_TASK: begin
                nxt_cur.ip = cmd.target & ipMask;
                nxt_cur.flags[SFI_BIT_NEST] = cmd.linkIn;
            end
            default: begin
            end
        endcase
        if (transfer) begin
            nxt_cur.fetch = nxt_cur.ip;
        end
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur.flags    <= SFI_FLAGS_RESET;
            cur.ip       <= IP_RESET;
            cur.fetch    <= IP_RESET;
            cur.pushVal  <= 64'h0;
            cur.stepTrap <= 1'b0;
            cur.intrSync <= 2'h0;
        end else if (clkEn) begin
            cur <= nxt_cur;
        end
    end

    // pointer-relative addressing uses the pointer of the next instruction
    sfi_ea_gen u_ea (
        .nextIp  (seqIp),
        .disp    (cmd.disp),
        .mode64  (env.mode64),
        .effAddr (ripRelAddr)
    );

    // misalignment mask by access size
    always_comb begin
        unique case (env.memSize)
            2'h0: sizeMask = 3'h0;
            2'h1: sizeMask = 3'h1;
            2'h2: sizeMask = 3'h3;
            2'h3: sizeMask = 3'h7;
        endcase
    end

    // outputs; upper half of the widened word reads as zero
    always_comb begin
        flagsWord       = {32'h0, cur.flags};
        ipOut           = cur.ip;
        fetchAddr       = cur.fetch;
        pushValue       = cur.pushVal;
        stepTrap        = cur.stepTrap;
        intrAccept      = cur.intrSync[1] && cur.flags[SFI_BIT_INTEN];
        ioAllowed       = (env.current_privilege_level <= io_privilege_level);
        alignFault      = env.memValid && cur.flags[SFI_BIT_ALIGN] && env.alignMaskBit
                          && ((env.memAddrLow & sizeMask) != 3'h0);
        debugFault      = env.bpHit && !cur.flags[SFI_BIT_RESUME];
        v86Mode         = cur.flags[SFI_BIT_V86];
        // the pending flag is only read here; the block writes it only on interrupt-return at level 0
        virtIntrPending = env.vmeEnable && cur.flags[SFI_BIT_VIMAGE]
                          && cur.flags[SFI_BIT_VPEND];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_popfLow;
        clkEn && (cmd.op == SFI_OP_POP_FLAGS_INSTR) && (env.current_privilege_level != SFI_CPL0);
    endsequence

    sequence s_callIssue;
        clkEn && (cmd.op == SFI_OP_CALL);
    endsequence

    chk_io_privilege_level_guard: assert property (
        s_popfLow |=> ($stable(flagsWord[SFI_BIT_IO_PRIVILEGE_LEVEL_HI:SFI_BIT_IO_PRIVILEGE_LEVEL_LO])))
        else $error("io privilege changed outside level 0");

    chk_io_privilege_level_only_load: assert property (
        (clkEn && (cmd.op != SFI_OP_POP_FLAGS_INSTR) && (cmd.op != SFI_OP_INTERRUPT_RETURN_INSTR))
        |=> $stable(flagsWord[SFI_BIT_IO_PRIVILEGE_LEVEL_HI:SFI_BIT_IO_PRIVILEGE_LEVEL_LO]))
        else $error("io privilege changed by other operation");

    chk_step_trap: assert property (
        (clkEn && (cmd.op != SFI_OP_NONE) && flagsWord[SFI_BIT_STEP]) |=> stepTrap)
        else $error("single step trap missing");

    chk_no_step: assert property (
        (clkEn && !flagsWord[SFI_BIT_STEP]) |=> !stepTrap)
        else $error("step trap without step flag");

    chk_intr_gate: assert property (
        intrAccept |-> flagsWord[SFI_BIT_INTEN])
        else $error("interrupt accepted while disabled");

    chk_io_priv: assert property (
        ioAllowed == (env.current_privilege_level <= flagsWord[SFI_BIT_IO_PRIVILEGE_LEVEL_HI:SFI_BIT_IO_PRIVILEGE_LEVEL_LO]))
        else $error("io permission wrong");

    chk_align_both: assert property (
        alignFault |-> (flagsWord[SFI_BIT_ALIGN] && env.alignMaskBit && env.memValid))
        else $error("alignment fault without both enables");

    chk_vpend_hold: assert property (
        (clkEn && (cmd.op != SFI_OP_POP_FLAGS_INSTR) && (cmd.op != SFI_OP_INTERRUPT_RETURN_INSTR))
        |=> $stable(flagsWord[SFI_BIT_VPEND]))
        else $error("pending flag modified by hardware");

    chk_upper_zero: assert property (
        flagsWord[63:32] == 32'h0 && flagsWord[SFI_BIT_FIXED1])
        else $error("reserved flag bits wrong");

    chk_call_push: assert property (
        s_callIssue |=> (pushValue == (($past(ipOut) + {60'h0, $past(cmd.len)})
                         & ($past(env.mode64) ? '1 : SFI_ADDR32_MASK))))
        else $error("call pushed wrong return pointer");

    chk_ret_load: assert property (
        (clkEn && (cmd.op == SFI_OP_RET) && env.mode64) |=> (ipOut == $past(cmd.stackVal)))
        else $error("return did not load pointer");

    chk_seq_step: assert property (
        (clkEn && (cmd.op == SFI_OP_SEQ) && env.mode64)
        |=> (ipOut == $past(ipOut) + {60'h0, $past(cmd.len)}))
        else $error("pointer did not advance");

    chk_ip_idle: assert property (
        (clkEn && (cmd.op == SFI_OP_NONE)) |=> $stable(ipOut))
        else $error("pointer changed with no instruction");

    chk_fetch_reload: assert property (
        (clkEn && (cmd.op == SFI_OP_JMP)) |=> (fetchAddr == ipOut))
        else $error("prefetch not redirected by jump");

    chk_resume_clear: assert property (
        (clkEn && (cmd.op == SFI_OP_SEQ)) |=> !flagsWord[SFI_BIT_RESUME])
        else $error("resume flag survived a retired instruction");

    chk_rel_addr: assert property (
        env.mode64 |-> (ripRelAddr == ipOut + {60'h0, cmd.len}
                        + {{32{cmd.disp[31]}}, cmd.disp}))
        else $error("relative address wrong");
endmodule : sfi_flags_ip
`default_nettype wire

// ---- common/sfi_pkg.sv ----
`default_nettype none
package sfi_pkg;
    // widths of the architectural words
    localparam int SFI_IP_W    = 64;
    localparam int SFI_FLAGS_W = 32;
    localparam int SFI_WIDE_W  = 64;

    // flag bit positions inside the flags word
    localparam int SFI_BIT_FIXED1  = 1;
    localparam int SFI_BIT_STEP    = 8;
    localparam int SFI_BIT_INTEN   = 9;
    localparam int SFI_BIT_IO_PRIVILEGE_LEVEL_LO = 12;
    localparam int SFI_BIT_IO_PRIVILEGE_LEVEL_HI = 13;
    localparam int SFI_BIT_NEST    = 14;
    localparam int SFI_BIT_RESUME  = 16;
    localparam int SFI_BIT_V86     = 17;
    localparam int SFI_BIT_ALIGN   = 18;
    localparam int SFI_BIT_VIMAGE  = 19;
    localparam int SFI_BIT_VPEND   = 20;
    localparam int SFI_BIT_PROBE   = 21;

    // reset value and write masks of the flags word
    localparam logic [31:0] SFI_FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] SFI_FIXED_ONES  = 32'h0000_0002;
    localparam logic [31:0] SFI_POP_FLAGS_INSTR_MASK   = 32'h0024_4DD5;
    localparam logic [31:0] SFI_INTERRUPT_RETURN_INSTR_MASK   = 32'h0025_4DD5;
    localparam logic [31:0] SFI_IO_PRIVILEGE_LEVEL_MASK   = 32'h0000_3000;
    localparam logic [31:0] SFI_INTERRUPT_RETURN_INSTR_PRIV   = 32'h001A_3000;

    // pointer and privilege-level constants
    localparam logic [63:0] SFI_IP_RESET    = 64'h0000_0000_0000_FFF0;
    localparam logic [63:0] SFI_ADDR32_MASK = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] SFI_FETCH_STEP  = 64'h0000_0000_0000_0010;
    localparam logic [1:0]  SFI_CPL0        = 2'h0;
    localparam logic [1:0]  SFI_IO_PRIVILEGE_LEVEL_TOP    = 2'h3;

    // operations retired by the execution unit
    typedef enum logic [3:0] {
        SFI_OP_NONE, SFI_OP_SEQ, SFI_OP_JMP, SFI_OP_JCC, SFI_OP_CALL,
        SFI_OP_RET, SFI_OP_INTERRUPT_RETURN_INSTR, SFI_OP_INTR, SFI_OP_POP_FLAGS_INSTR, SFI_OP_CLI,
        SFI_OP_STI, SFI_OP_TASK
    } sfi_op_e;

    typedef struct packed {
        sfi_op_e     op;
        logic [3:0]  len;
        logic        jccTaken;
        logic        linkIn;
        logic [63:0] target;
        logic [63:0] stackVal;
        logic [31:0] flagsVal;
        logic [31:0] disp;
    } sfi_cmd_s;

    typedef struct packed {
        logic [1:0] current_privilege_level;
        logic       mode64;
        logic       alignMaskBit;
        logic       vmeEnable;
        logic       bpHit;
        logic       memValid;
        logic [2:0] memAddrLow;
        logic [1:0] memSize;
    } sfi_env_s;

    typedef struct packed {
        logic [31:0] flags;
        logic [63:0] ip;
        logic [63:0] fetch;
        logic [63:0] pushVal;
        logic        stepTrap;
        logic [1:0]  intrSync;
    } sfi_state_s;
endpackage : sfi_pkg
`default_nettype wire

// ---- rtl/sfi_ea_gen.sv ----
`default_nettype none
// pointer-relative address: next pointer plus sign-extended displacement
module sfi_ea_gen
    import sfi_pkg::*;
(
    input  wire logic [63:0] nextIp,
    input  wire logic [31:0] disp,
    input  wire logic        mode64,
    output logic      [63:0] effAddr
);
    logic [63:0] sum;

    // outside 64-bit mode the sum wraps inside the 32-bit space
    always_comb begin
        sum     = nextIp + {{32{disp[31]}}, disp};
        effAddr = mode64 ? sum : (sum & SFI_ADDR32_MASK);
    end
endmodule : sfi_ea_gen
`default_nettype wire

// ---- test/sfi_flags_ip_test.sv ----
`default_nettype none
module sfi_flags_ip_test
    import sfi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // one retired op with the state expected after it
    typedef struct packed {
        sfi_op_e     op;
        logic [3:0]  len;
        logic [1:0]  current_privilege_level;
        logic        b;
        logic [63:0] tgt;
        logic [31:0] fv;
        logic [63:0] ip;
        logic [31:0] f;
        logic [63:0] pv;
        logic        st;
    } sfi_row_s;

    logic        clock = 1'h0;
    logic        rstn = 1'h0;
    logic        clkEn = 1'h1;
    logic        intrPin = 1'h0;
    logic        fetchAck = 1'h0;
    sfi_cmd_s    cmd = '0;
    sfi_env_s    env = '{mode64: 1'h1, default: '0};
    logic [63:0] flagsWord, ipOut, fetchAddr, pushValue, ripRelAddr;
    logic        stepTrap, intrAccept, ioAllowed, alignFault;
    logic        debugFault, v86Mode, virtIntrPending;
    int          n_errors = 0;
    int          compares = 0;
    sfi_row_s    rows [19];

    // free-running core clock, 40 ns period
    always #20 clock = ~clock;

    sfi_flags_ip u_sfi_flags_ip (
        .clock(clock), .rstn(rstn), .clkEn(clkEn), .cmd(cmd), .env(env),
        .intrPin(intrPin), .fetchAck(fetchAck), .flagsWord(flagsWord),
        .ipOut(ipOut), .fetchAddr(fetchAddr), .pushValue(pushValue),
        .stepTrap(stepTrap), .intrAccept(intrAccept), .ioAllowed(ioAllowed),
        .alignFault(alignFault), .debugFault(debugFault), .v86Mode(v86Mode),
        .virtIntrPending(virtIntrPending), .ripRelAddr(ripRelAddr)
    );

    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk64

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk1

    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // op is held for one edge only, then the state is sampled mid-cycle
    task automatic run_op(input sfi_row_s r);
        @(posedge clock);
        cmd.op <= r.op;
        cmd.len <= r.len;
        cmd.jccTaken <= r.b;
        cmd.linkIn <= r.b;
        cmd.target <= r.tgt;
        cmd.stackVal <= r.tgt;
        cmd.flagsVal <= r.fv;
        env.current_privilege_level <= r.current_privilege_level;
        @(posedge clock);
        cmd.op <= SFI_OP_NONE;
        @(negedge clock);
        chk64(ipOut, r.ip);
        chk64(flagsWord, {32'h0, r.f});
        chk64(pushValue, r.pv);
        chk1(stepTrap, r.st);
    endtask : run_op

    task automatic chk_reset();
        chk64(flagsWord, 64'h2);
        chk64(ipOut, 64'hFFF0);
        chk64(fetchAddr, 64'hFFF0);
        chk64(pushValue, 64'h0);
    endtask : chk_reset

    // main sequence: table of ordinary ops, then hand-written corners
    initial begin
        rows[0] = '{SFI_OP_SEQ, 4'h3, 2'h0, 1'h0, 64'h0, 32'h0, 64'hFFF3, 32'h2, 64'h0, 1'h0};
        rows[1] = '{SFI_OP_POP_FLAGS_INSTR, 4'h1, 2'h0, 1'h0, 64'h0, 32'hFFFFFFFF, 64'hFFF4, 32'h247FD7,
                    64'h0, 1'h0};
        rows[2] = '{SFI_OP_POP_FLAGS_INSTR, 4'h1, 2'h3, 1'h0, 64'h0, 32'h0, 64'hFFF5, 32'h3002, 64'h0,
                    1'h1};
        rows[3] = '{SFI_OP_POP_FLAGS_INSTR, 4'h1, 2'h0, 1'h0, 64'h0, 32'h200, 64'hFFF6, 32'h202, 64'h0,
                    1'h0};
        rows[4] = '{SFI_OP_POP_FLAGS_INSTR, 4'h1, 2'h3, 1'h0, 64'h0, 32'h3000, 64'hFFF7, 32'h202, 64'h0,
                    1'h0};
        rows[5] = '{SFI_OP_CLI, 4'h1, 2'h3, 1'h0, 64'h0, 32'h0, 64'hFFF8, 32'h202, 64'h0,
                    1'h0};
        rows[6] = '{SFI_OP_CLI, 4'h1, 2'h0, 1'h0, 64'h0, 32'h0, 64'hFFF9, 32'h2, 64'h0, 1'h0};
        rows[7] = '{SFI_OP_STI, 4'h1, 2'h0, 1'h0, 64'h0, 32'h0, 64'hFFFA, 32'h202, 64'h0, 1'h0};
        rows[8] = '{SFI_OP_JMP, 4'h2, 2'h0, 1'h0, 64'h1000, 32'h0, 64'h1000, 32'h202, 64'h0, 1'h0};
        rows[9] = '{SFI_OP_CALL, 4'h5, 2'h0, 1'h0, 64'h2000, 32'h0, 64'h2000, 32'h202, 64'h1005,
                    1'h0};
        rows[10] = '{SFI_OP_RET, 4'h1, 2'h0, 1'h0, 64'h1234, 32'h0, 64'h1234, 32'h202, 64'h1005,
                     1'h0};
        rows[11] = '{SFI_OP_JCC, 4'h2, 2'h0, 1'h1, 64'h3000, 32'h0, 64'h3000, 32'h202, 64'h1005,
                     1'h0};
        rows[12] = '{SFI_OP_JCC, 4'h2, 2'h0, 1'h0, 64'h5555, 32'h0, 64'h3002, 32'h202, 64'h1005,
                     1'h0};
        rows[13] = '{SFI_OP_TASK, 4'h1, 2'h0, 1'h1, 64'h4000, 32'h0, 64'h4000, 32'h4202,
                     64'h1005, 1'h0};
        rows[14] = '{SFI_OP_INTR, 4'h1, 2'h0, 1'h0, 64'h5000, 32'h0, 64'h5000, 32'h2, 64'h4000,
                     1'h0};
        rows[15] = '{SFI_OP_INTERRUPT_RETURN_INSTR, 4'h1, 2'h0, 1'h0, 64'h6000, 32'hFFFFFFFF, 64'h6000,
                     32'h3F7FD7, 64'h4000, 1'h0};
        rows[16] = '{SFI_OP_TASK, 4'h1, 2'h0, 1'h0, 64'h7000, 32'h0, 64'h7000, 32'h3E3FD7,
                     64'h4000, 1'h1};
        rows[17] = '{SFI_OP_INTERRUPT_RETURN_INSTR, 4'h1, 2'h3, 1'h0, 64'h8000, 32'h0, 64'h8000, 32'h1A3002,
                     64'h4000, 1'h1};
        rows[18] = '{SFI_OP_JMP, 4'h1, 2'h0, 1'h0, 64'h0123456789ABCDEF, 32'h0,
                     64'h0123456789ABCDEF, 32'h1A3002, 64'h4000, 1'h0};
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk_reset();
        @(posedge clock);
        rstn <= 1'h1;
        foreach (rows[i]) run_op(rows[i]);
        // virtual flags only count with the extensions enabled
        @(negedge clock);
        chk1(v86Mode, 1'h1);
        chk1(virtIntrPending, 1'h0);
        @(posedge clock);
        env.vmeEnable <= 1'h1;
        @(negedge clock);
        chk1(virtIntrPending, 1'h1);
        run_op(sfi_row_s'{SFI_OP_POP_FLAGS_INSTR, 4'h1, 2'h0, 1'h0, 64'h0, 32'h41000,
                          64'h0123456789ABCDF0, 32'h1E1002, 64'h4000, 1'h0});
        for (int c = 0; c < 4; c++) begin
            @(posedge clock);
            env.current_privilege_level <= 2'(c);
            @(negedge clock);
            chk1(ioAllowed, c <= 1);
        end
        @(posedge clock);
        cmd.len <= 4'h6;
        cmd.disp <= 32'hFFFFFFF0;
        @(negedge clock);
        chk64(ripRelAddr, 64'h0123456789ABCDE6);
        @(posedge clock);
        env.mode64 <= 1'h0;
        @(negedge clock);
        chk64(ripRelAddr, 64'h89ABCDE6);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            env.mode64 <= 1'h1;
            env.alignMaskBit <= k[0];
            env.memValid <= 1'h1;
            env.memSize <= 2'h2;
            env.memAddrLow <= k[1] ? 3'h1 : 3'h4;
            @(negedge clock);
            chk1(alignFault, k[0] & k[1]);
        end
        @(posedge clock);
        env.bpHit <= 1'h1;
        @(negedge clock);
        chk1(debugFault, 1'h1);
        run_op(sfi_row_s'{SFI_OP_INTERRUPT_RETURN_INSTR, 4'h1, 2'h0, 1'h0, 64'h9000, 32'h10000, 64'h9000,
                          32'h10002, 64'h4000, 1'h0});
        chk1(debugFault, 1'h0);
        chk1(v86Mode, 1'h0);
        run_op(sfi_row_s'{SFI_OP_STI, 4'h1, 2'h0, 1'h0, 64'h0, 32'h0, 64'h9001, 32'h202,
                          64'h4000, 1'h0});
        // the request pin passes two flops before it counts
        @(posedge clock);
        intrPin <= 1'h1;
        @(negedge clock);
        chk1(intrAccept, 1'h0);
        // first flop has it now, second one only after the next edge
        @(negedge clock);
        chk1(intrAccept, 1'h0);
        @(negedge clock);
        chk1(intrAccept, 1'h1);
        run_op(sfi_row_s'{SFI_OP_CLI, 4'h1, 2'h0, 1'h0, 64'h0, 32'h0, 64'h9002, 32'h2,
                          64'h4000, 1'h0});
        chk1(intrAccept, 1'h0);
        // a frozen clock enable must swallow the jump
        @(posedge clock);
        clkEn <= 1'h0;
        cmd.op <= SFI_OP_JMP;
        @(posedge clock);
        clkEn <= 1'h1;
        cmd.op <= SFI_OP_SEQ;
        cmd.len <= 4'h2;
        @(posedge clock);
        cmd.len <= 4'h3;
        @(posedge clock);
        cmd.op <= SFI_OP_NONE;
        @(negedge clock);
        chk64(ipOut, 64'h9007);
        // mid-run reset, then the prefetch runs ahead of the pointer
        @(posedge clock);
        rstn <= 1'h0;
        @(negedge clock);
        chk_reset();
        @(posedge clock);
        rstn <= 1'h1;
        fetchAck <= 1'h1;
        @(posedge clock);
        fetchAck <= 1'h0;
        @(negedge clock);
        chk64(fetchAddr, 64'h10000);
        chk64(ipOut, 64'hFFF0);
        final_report();
    end
endmodule : sfi_flags_ip_test
`default_nettype wire
